// File: disk_cmd_pkg.sv
// Purpose: Shared constants for the disk command descriptor decoder
// Assumes: Six-byte descriptors, one byte per accepted transfer
// Notes: Error codes are six bits wide, as carried in the error byte
package disk_cmd_pkg;
  // Descriptor geometry
  localparam int DESC_BYTES = 6;
  localparam int LBA_W = 21;
  localparam int STEP_W = 4;
  // Byte 0 and byte 1 field positions
  localparam int CLASS_LSB = 5;
  localparam int OPC_W = 5;
  localparam int LUN_LSB = 5;
  localparam int LBA_HI_W = 5;
  // Control byte bit positions
  localparam int CTL_RETRY_DIS = 7;
  localparam int CTL_IMM_ECC = 6;
  localparam int CTL_FILL_BUF = 5;
  localparam int CTL_RSVD = 4;
  // Class and operation codes handled here
  localparam logic [2:0] CLASS_CMD = 3'h0;
  localparam logic [4:0] OPC_FMT_DRIVE = 5'h04;
  localparam logic [4:0] OPC_CHK_TRACK = 5'h05;
  localparam logic [4:0] OPC_FMT_TRACK = 5'h06;
  localparam logic [4:0] OPC_FMT_BAD = 5'h07;
  localparam logic [4:0] OPC_READ = 5'h08;
  // Completion codes
  localparam logic [5:0] ERR_NONE = 6'h00;
  localparam logic [5:0] ERR_WR_FAULT = 6'h03;
  localparam logic [5:0] ERR_NOT_READY = 6'h04;
  localparam logic [5:0] ERR_UNCORR = 6'h11;
  localparam logic [5:0] ERR_NO_AM = 6'h12;
  localparam logic [5:0] ERR_SEEK = 6'h15;
  localparam logic [5:0] ERR_CORRECTED = 6'h18;
  localparam logic [5:0] ERR_BAD_TRACK = 6'h19;
  localparam logic [5:0] ERR_FORMAT = 6'h1A;
  localparam logic [5:0] ERR_ALT_DIRECT = 6'h1C;
  localparam logic [5:0] ERR_ALT_UNMARKED = 6'h1E;
  localparam logic [5:0] ERR_ALT_SAME = 6'h1F;
  localparam logic [5:0] ERR_INVALID = 6'h20;
  localparam logic [5:0] ERR_BAD_ADDR = 6'h21;
  localparam logic [5:0] ERR_SELFTEST = 6'h30;
  // Constant written into data fields when the buffer is not used
  localparam logic [7:0] FILL_BYTE = 8'h6C;
  // Work handed to the track engine
  typedef enum logic [2:0] {OP_NONE, OP_FMT_ALL, OP_FMT_ONE, OP_CHECK, OP_BAD, OP_READ} op_kind_t;
endpackage

// File: desc_capture.sv
// Purpose: Collect the six descriptor bytes from the host stream
// Assumes: Host logic on clk_sys; byte taken when in_valid and in_ready
// Notes: Frame held in desc until the first byte of the next frame arrives
module desc_capture #(
  parameter int NBYTES = disk_cmd_pkg::DESC_BYTES
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Permission from the decoder to take a frame
  input wire logic take,
  // Byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic in_ready,
  // Assembled frame, byte k at bits 8k+7..8k
  output logic [NBYTES*8-1:0] desc,
  output logic frame
);
  import disk_cmd_pkg::*;
  localparam int IW = $clog2(NBYTES);
  localparam logic [IW-1:0] LAST = IW'(NBYTES - 1);
  logic [IW-1:0] idx_reg; // Next byte position

  // Bytes land in ascending order, first byte is class and opcode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= '0;
      in_ready <= 1'b0;
      frame <= 1'b0;
      desc <= '0;
    end else if (ce) begin
      frame <= 1'b0;
      if (in_valid && in_ready) begin
        desc[idx_reg*8 +: 8] <= in_byte;
        // Ready drops with the last byte so a next frame cannot slip in
        if (idx_reg == LAST) begin
          idx_reg <= '0;
          in_ready <= 1'b0;
          frame <= 1'b1;
        end else begin
          idx_reg <= idx_reg + 1'b1;
        end
      end else begin
        in_ready <= take && !frame;
      end
    end
  end
endmodule

// File: bad_track_map.sv
// Purpose: One bit per track, set when the track carries bad marks
// Assumes: Contents undefined at power up; the decoder sweeps it clear
// Notes: Read data is registered, valid one cycle after raddr
module bad_track_map #(
  parameter int AW = 16
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic rdata
);
  logic mem [2**AW]; // Track marks, no reset to keep it a RAM

  // Array write
  always_ff @(posedge clk_sys) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 1'b0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// File: disk_cmd_decoder.sv
// Purpose: Decode, validate and sequence format, check and read descriptors
// Assumes: Track engine and host logic share clk_sys; engine acks once per request
// Notes: A track is lba[SPT_LOG2 +: TRK_W]; SPT_LOG2 + TRK_W must not exceed 21
// Overview of operation
// - Byte 0 holds class high, opcode low.
// - Byte 1 unit and high address; bytes 2-3 rest.
// - Control bit 7 disables retries; bad track ignores.
// - Low four control bits pick fast step.
// - Format fill: bit 5 zero constant, else buffer.
// - Opcode 4 formats addressed track to last.
// - Opcode 5 checks interleave from headers only.
// - Opcode 6 formats the single addressed track.
// - Opcode 7 marks track bad; reads refused after.
// - Read sector count comes from byte 4.
// - Bad class, opcode, unit, interleave, step give 20.
// - Code 1F never comes from these commands.
// - Self-test failure ends the command with 30.
// - Format drive and track: limited outcome set.
// - Check track format: limited outcome set.
// - Format bad track: no seek verify, limited outcomes.
// - Read walks consecutive sectors from the address.
// - Check reports 1A on header mismatch in a clean pass.
module disk_cmd_decoder #(
  parameter int SPT_LOG2 = 5,
  parameter int TRK_W = 16,
  parameter int NUM_LUN = 4,
  parameter logic [3:0] MAX_STEP = 4'h7,
  parameter int RETRY_MAX = 3
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Host descriptor stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  // Completion
  output logic busy,
  output logic done,
  output logic [5:0] done_code,
  // Self-test results
  input wire logic rom_sum_bad,
  input wire logic ram_bad,
  input wire logic cpu_bad,
  // Drive geometry
  input wire logic [TRK_W-1:0] last_track,
  // Track engine request
  output logic op_req,
  output disk_cmd_pkg::op_kind_t op_kind,
  output logic [2:0] op_lun,
  output logic [disk_cmd_pkg::LBA_W-1:0] op_lba,
  output logic [7:0] op_ilv,
  output logic [disk_cmd_pkg::STEP_W-1:0] op_step,
  output logic op_retry_dis,
  output logic op_imm_ecc,
  output logic op_fill_buf,
  output logic [7:0] op_fill_byte,
  output logic op_hdr_only,
  output logic op_verify,
  // Track engine answer
  input wire logic op_ack,
  input wire logic [5:0] op_code,
  input wire logic [7:0] chk_ilv,
  input wire logic chk_unformatted,
  input wire logic chk_hdr_bad
);
  import disk_cmd_pkg::*;

  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_CHECK, ST_LOOK, ST_SEE, ST_ISSUE, ST_WAIT, ST_FINISH} state_t;
  localparam logic [LBA_W-1:0] TRK_STEP = LBA_W'(1) << SPT_LOG2; // One track in sectors
  localparam logic [TRK_W-1:0] TRK_LAST_IDX = '1; // End of init sweep
  localparam logic [7:0] SPT = 8'(1 << SPT_LOG2); // Sectors per track
  localparam logic [1:0] TRY_LIMIT = 2'(RETRY_MAX); // Retries after first try

  state_t state_reg; // Sequencer state
  logic [DESC_BYTES*8-1:0] desc; // Captured frame
  logic frame; // Frame complete pulse
  op_kind_t kind_reg; // Latched operation
  logic [2:0] lun_reg; // Latched unit
  logic [LBA_W-1:0] lba_reg; // Current sector or track start
  logic [7:0] ilv_reg; // Interleave
  logic [7:0] cnt_reg; // Sectors left, zero means 256
  logic [STEP_W-1:0] step_reg; // Fast step option
  logic retry_dis_reg; // Retry suppress
  logic imm_ecc_reg; // Immediate correction
  logic fill_buf_reg; // Fill from buffer
  logic [1:0] tries_reg; // Retries used on this request
  logic corrected_reg; // Some sector was corrected
  logic [5:0] code_reg; // Final code
  logic [TRK_W-1:0] init_addr_reg; // Clear sweep address
  logic bad_rd; // Map read data

  // Descriptor fields
  logic [2:0] d_class;
  logic [4:0] d_opc;
  logic [2:0] d_lun;
  logic [LBA_W-1:0] d_lba;
  logic [7:0] d_b4;
  logic [7:0] d_ctl;
  assign d_class = desc[CLASS_LSB +: 3];
  assign d_opc = desc[0 +: OPC_W];
  assign d_lun = desc[8 + LUN_LSB +: 3];
  assign d_lba = {desc[8 +: LBA_HI_W], desc[16 +: 8], desc[24 +: 8]};
  assign d_b4 = desc[32 +: 8];
  assign d_ctl = desc[40 +: 8];

  // Opcode to operation
  op_kind_t d_kind;
  always_comb begin
    unique case (d_opc)
      OPC_FMT_DRIVE: d_kind = OP_FMT_ALL;
      OPC_CHK_TRACK: d_kind = OP_CHECK;
      OPC_FMT_TRACK: d_kind = OP_FMT_ONE;
      OPC_FMT_BAD: d_kind = OP_BAD;
      OPC_READ: d_kind = OP_READ;
      default: d_kind = OP_NONE;
    endcase
  end

  // Validation verdict, worked out before anything moves
  logic st_bad;
  logic d_invalid;
  logic [5:0] chk_code;
  assign st_bad = rom_sum_bad || ram_bad || cpu_bad;
  always_comb begin
    d_invalid = (d_class != CLASS_CMD) || (d_kind == OP_NONE) || (32'(d_lun) >= NUM_LUN)
      || (d_ctl[STEP_W-1:0] > MAX_STEP);
    // Interleave must name a sector slot within one track
    if (d_kind != OP_READ && (d_b4 == 8'h00 || d_b4 >= SPT)) begin
      d_invalid = 1'b1;
    end
    if (st_bad) begin
      chk_code = ERR_SELFTEST;
    end else if (d_invalid) begin
      chk_code = ERR_INVALID;
    end else if (d_lba[SPT_LOG2 +: TRK_W] > last_track) begin
      chk_code = ERR_BAD_ADDR;
    end else begin
      chk_code = ERR_NONE;
    end
  end

  // Outcomes each operation may legally end with
  function automatic logic allowed(input op_kind_t k, input logic [5:0] c);
    logic base;
    base = (c == ERR_NONE) || (c == ERR_INVALID) || (c == ERR_BAD_ADDR)
      || (c == ERR_NOT_READY) || (c == ERR_WR_FAULT) || (c == ERR_SELFTEST);
    unique case (k)
      OP_FMT_ALL, OP_FMT_ONE: allowed = base || (c == ERR_SEEK);
      OP_CHECK: allowed = base || (c == ERR_SEEK) || (c == ERR_FORMAT);
      OP_BAD: allowed = base;
      OP_READ: allowed = base || (c == ERR_SEEK) || (c == ERR_BAD_TRACK) || (c == ERR_ALT_DIRECT)
        || (c == ERR_ALT_UNMARKED) || (c == ERR_NO_AM) || (c == ERR_CORRECTED) || (c == ERR_UNCORR);
      OP_NONE: allowed = base;
    endcase
  endfunction

  // Engine answer after the header check and the outcome filter
  logic [5:0] raw_code;
  logic [5:0] eff_code;
  logic eff_ok;
  always_comb begin
    raw_code = op_code;
    // Any header mismatch on a clean pass is a format error
    if (kind_reg == OP_CHECK && op_code == ERR_NONE
        && (chk_unformatted || chk_hdr_bad || chk_ilv != ilv_reg)) begin
      raw_code = ERR_FORMAT;
    end
    // Foreign codes, 1F among them, fold into drive not ready
    eff_code = allowed(kind_reg, raw_code) ? raw_code : ERR_NOT_READY;
    eff_ok = (eff_code == ERR_NONE) || (eff_code == ERR_CORRECTED);
  end

  // Current track and the engine answer test
  logic [TRK_W-1:0] cur_trk;
  logic ack_seen;
  assign cur_trk = lba_reg[SPT_LOG2 +: TRK_W];
  assign ack_seen = state_reg == ST_WAIT && op_ack && !op_req;

  // Map writes: clear sweep, then marks follow format results
  logic map_we;
  logic [TRK_W-1:0] map_waddr;
  logic map_wdata;
  assign map_we = (state_reg == ST_INIT) || (ack_seen && eff_ok
    && (kind_reg == OP_BAD || kind_reg == OP_FMT_ALL || kind_reg == OP_FMT_ONE));
  assign map_waddr = (state_reg == ST_INIT) ? init_addr_reg : cur_trk;
  assign map_wdata = (state_reg != ST_INIT) && (kind_reg == OP_BAD);

  desc_capture #(
    .NBYTES(DESC_BYTES)
  ) u_capture (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .take(state_reg == ST_IDLE),
    .in_valid(cmd_valid),
    .in_byte(cmd_byte),
    .in_ready(cmd_ready),
    .desc(desc),
    .frame(frame)
  );

  bad_track_map #(
    .AW(TRK_W)
  ) u_map (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .we(map_we),
    .waddr(map_waddr),
    .wdata(map_wdata),
    .raddr(cur_trk),
    .rdata(bad_rd)
  );

  // Clear sweep of the map after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_addr_reg <= '0;
    end else if (ce && state_reg == ST_INIT) begin
      init_addr_reg <= init_addr_reg + 1'b1;
    end
  end

  // Sequencer and command context
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
      kind_reg <= OP_NONE;
      lun_reg <= '0;
      lba_reg <= '0;
      ilv_reg <= '0;
      cnt_reg <= '0;
      step_reg <= '0;
      retry_dis_reg <= 1'b0;
      imm_ecc_reg <= 1'b0;
      fill_buf_reg <= 1'b0;
      tries_reg <= '0;
      corrected_reg <= 1'b0;
      code_reg <= ERR_NONE;
    end else if (ce) begin
      unique case (state_reg)
        ST_INIT: begin
          if (init_addr_reg == TRK_LAST_IDX) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (frame) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          kind_reg <= d_kind;
          lun_reg <= d_lun;
          ilv_reg <= d_b4;
          cnt_reg <= d_b4;
          step_reg <= d_ctl[STEP_W-1:0];
          retry_dis_reg <= d_ctl[CTL_RETRY_DIS] && d_kind != OP_BAD;
          imm_ecc_reg <= d_ctl[CTL_IMM_ECC] && d_kind == OP_READ;
          fill_buf_reg <= d_ctl[CTL_FILL_BUF] && (d_kind == OP_FMT_ALL || d_kind == OP_FMT_ONE);
          tries_reg <= '0;
          corrected_reg <= 1'b0;
          // Formats work on whole tracks, so drop the sector bits
          lba_reg <= (d_kind == OP_READ) ? d_lba : (d_lba & ~(TRK_STEP - 1'b1));
          // Nothing reaches the engine unless the whole frame is clean
          if (chk_code != ERR_NONE) begin
            code_reg <= chk_code;
            state_reg <= ST_FINISH;
          end else if (d_kind == OP_READ) begin
            state_reg <= ST_LOOK;
          end else begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_LOOK: begin
          // Read ran off the drive end
          if (cur_trk > last_track) begin
            code_reg <= ERR_BAD_ADDR;
            state_reg <= ST_FINISH;
          end else begin
            state_reg <= ST_SEE;
          end
        end
        ST_SEE: begin
          // Marked tracks refuse their contents
          if (bad_rd) begin
            code_reg <= ERR_BAD_TRACK;
            state_reg <= ST_FINISH;
          end else begin
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ack_seen) begin
            if (!eff_ok) begin
              // Retry unless suppressed or the budget is spent
              if (!retry_dis_reg && tries_reg < TRY_LIMIT) begin
                tries_reg <= tries_reg + 1'b1;
                state_reg <= ST_ISSUE;
              end else begin
                code_reg <= eff_code;
                state_reg <= ST_FINISH;
              end
            end else begin
              tries_reg <= '0;
              corrected_reg <= corrected_reg || eff_code == ERR_CORRECTED;
              if (kind_reg == OP_FMT_ALL && cur_trk != last_track) begin
                lba_reg <= lba_reg + TRK_STEP;
                state_reg <= ST_ISSUE;
              end else if (kind_reg == OP_READ && cnt_reg != 8'h01) begin
                lba_reg <= lba_reg + 1'b1;
                cnt_reg <= cnt_reg - 1'b1;
                state_reg <= ST_LOOK;
              end else begin
                // Single track ops end after one pass, drive format and read after their last
                code_reg <= (corrected_reg || eff_code == ERR_CORRECTED) ? ERR_CORRECTED : ERR_NONE;
                state_reg <= ST_FINISH;
              end
            end
          end
        end
        ST_FINISH: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Engine request, one pulse per try on each track or sector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_req <= 1'b0;
      op_kind <= OP_NONE;
      op_lun <= '0;
      op_lba <= '0;
      op_ilv <= '0;
      op_step <= '0;
      op_retry_dis <= 1'b0;
      op_imm_ecc <= 1'b0;
      op_fill_buf <= 1'b0;
      op_fill_byte <= FILL_BYTE;
      op_hdr_only <= 1'b0;
      op_verify <= 1'b0;
    end else if (ce) begin
      op_req <= state_reg == ST_ISSUE;
      if (state_reg == ST_ISSUE) begin
        op_kind <= kind_reg;
        op_lun <= lun_reg;
        op_lba <= lba_reg;
        op_ilv <= ilv_reg;
        op_step <= step_reg;
        op_retry_dis <= retry_dis_reg;
        op_imm_ecc <= imm_ecc_reg;
        op_fill_buf <= fill_buf_reg;
        op_fill_byte <= FILL_BYTE;
        op_hdr_only <= kind_reg == OP_CHECK;
        op_verify <= kind_reg != OP_BAD;
      end
    end
  end

  // Completion report
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      done_code <= ERR_NONE;
      busy <= 1'b1;
    end else if (ce) begin
      done <= state_reg == ST_FINISH;
      busy <= !(state_reg == ST_IDLE && !frame) || state_reg == ST_FINISH;
      if (state_reg == ST_FINISH) begin
        done_code <= code_reg;
      end
    end
  end

  property p_invalid_code;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_reg == ST_CHECK && !st_bad && d_invalid) |=> ##1 (done && done_code == ERR_INVALID);
  endproperty
  a_invalid_code: assert property (p_invalid_code) else $error("invalid frame not ended with 20");

  property p_no_motion;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_reg == ST_CHECK && chk_code != ERR_NONE) |=> !op_req [*3];
  endproperty
  a_no_motion: assert property (p_no_motion) else $error("engine started on a rejected frame");

  property p_selftest;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_reg == ST_CHECK && st_bad) |-> ##2 (done && done_code == ERR_SELFTEST);
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test failure not ended with 30");

  property p_bad_retry;
    @(posedge clk_sys) disable iff (!rst_n)
    (op_req && op_kind == OP_BAD) |-> !op_retry_dis;
  endproperty
  a_bad_retry: assert property (p_bad_retry) else $error("bad track request suppressed retries");

  property p_fill;
    @(posedge clk_sys) disable iff (!rst_n)
    (op_req && op_kind != OP_FMT_ALL && op_kind != OP_FMT_ONE) |-> !op_fill_buf && op_fill_byte == FILL_BYTE;
  endproperty
  a_fill: assert property (p_fill) else $error("buffer fill outside a format");

  property p_hdr_only;
    @(posedge clk_sys) disable iff (!rst_n)
    op_req |-> (op_hdr_only == (op_kind == OP_CHECK)) && (op_verify == (op_kind != OP_BAD));
  endproperty
  a_hdr_only: assert property (p_hdr_only) else $error("header-only or verify flag wrong");

  property p_no_1f;
    @(posedge clk_sys) disable iff (!rst_n)
    done |-> done_code != ERR_ALT_SAME;
  endproperty
  a_no_1f: assert property (p_no_1f) else $error("code 1F reported");

  property p_outcome;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(done) |-> allowed(kind_reg, done_code) || done_code == ERR_BAD_ADDR;
  endproperty
  a_outcome: assert property (p_outcome) else $error("outcome outside the command's set");

  property p_count;
    @(posedge clk_sys) disable iff (!rst_n)
    (ce && state_reg == ST_CHECK && chk_code == ERR_NONE && d_kind == OP_READ) |=> cnt_reg == $past(d_b4);
  endproperty
  a_count: assert property (p_count) else $error("sector count not taken from byte 4");
endmodule

// File: track_engine_model.sv
// Purpose: Track engine stand-in answering decoder requests
// Assumes: One request outstanding, same clock as the decoder
// Notes: Result code changes every cycle outside the answer
module track_engine_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Request and answer setup
  input wire logic op_req,
  input wire logic [1:0] lat,
  input wire logic [5:0] code_in,
  // Answer
  output logic op_ack,
  output logic [5:0] op_code,
  output logic [7:0] n_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt; // Cycles left to the answer
  // Answer 1 to 4 cycles after a request, never in its own cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      op_ack <= 1'b0;
      n_req <= 8'h00;
    end else begin
      op_ack <= 1'b0;
      if (op_req) begin
        cnt <= {1'b0, lat} + 3'h1;
        n_req <= n_req + 8'h01;
      end else if (cnt == 3'h1) begin
        op_ack <= 1'b1;
        cnt <= 3'h0;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
    end
  end
  // Code valid only with the answer; flipping otherwise
  always_ff @(posedge clk_sys) begin
    op_code <= (cnt == 3'h1) ? code_in : ~op_code;
  end
endmodule

// File: disk_cmd_decoder_bench.sv
// Purpose: Self-checking bench for the descriptor decoder
// Assumes: Short map sweep (TRK_W 4), last track 3
// Notes: Rows are order dependent; bad mark set before the read
module disk_cmd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import disk_cmd_pkg::*;
  // One case: bytes 0..5, engine code, self-test, code, requests
  typedef struct {
    logic [47:0] d;
    logic [5:0] ec;
    logic [2:0] st;
    logic [5:0] ex;
    logic [7:0] nr;
  } row_t;
  row_t rows[19] = '{
    '{48'h0600_0000_0305, 6'h00, 3'h0, ERR_NONE, 8'h01},
    '{48'h2600_0000_0300, 6'h00, 3'h0, ERR_INVALID, 8'h00},
    '{48'h0680_0000_0300, 6'h00, 3'h0, ERR_INVALID, 8'h00},
    '{48'h0600_0000_0308, 6'h00, 3'h0, ERR_INVALID, 8'h00},
    '{48'h0600_0000_0000, 6'h00, 3'h0, ERR_INVALID, 8'h00},
    '{48'h1F00_0000_0300, 6'h00, 3'h0, ERR_INVALID, 8'h00},
    '{48'h0400_0040_0321, 6'h00, 3'h0, ERR_NONE, 8'h02},
    '{48'h0500_0000_0300, 6'h00, 3'h0, ERR_NONE, 8'h01},
    '{48'h0500_0000_0500, 6'h00, 3'h0, ERR_FORMAT, 8'h04},
    '{48'h0600_0000_0300, 6'h1F, 3'h0, ERR_NOT_READY, 8'h04},
    '{48'h0600_0000_0380, 6'h1F, 3'h0, ERR_NOT_READY, 8'h01},
    '{48'h0700_0020_0380, 6'h00, 3'h0, ERR_NONE, 8'h01},
    '{48'h0800_0020_0200, 6'h00, 3'h0, ERR_BAD_TRACK, 8'h00},
    '{48'h0800_0000_0240, 6'h00, 3'h0, ERR_NONE, 8'h02},
    '{48'h0800_0000_0200, 6'h18, 3'h0, ERR_CORRECTED, 8'h02},
    '{48'h0600_0080_0300, 6'h00, 3'h0, ERR_BAD_ADDR, 8'h00},
    '{48'h0600_0000_0300, 6'h00, 3'h1, ERR_SELFTEST, 8'h00},
    '{48'h0600_0000_0300, 6'h00, 3'h2, ERR_SELFTEST, 8'h00},
    '{48'h0600_0000_0300, 6'h00, 3'h4, ERR_SELFTEST, 8'h00}};
  // Design and model signals
  logic clk_sys;
  logic rst_n;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_ready;
  logic busy;
  logic done;
  logic [5:0] done_code;
  logic [2:0] st;
  logic op_req;
  logic [3:0] op_step;
  logic fb;
  logic [7:0] fill;
  logic op_ack;
  logic [5:0] op_code;
  logic [1:0] lat;
  logic [5:0] ec;
  logic [7:0] n_req;
  logic hb; // Header fault seen by the engine
  logic unf; // Track found unformatted
  logic [20:0] lba; // Last request address
  op_kind_t kind; // Last request kind
  int fail_count = 0;
  int comparisons = 0;
  disk_cmd_decoder #(.TRK_W(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .busy(busy), .done(done),
    .done_code(done_code), .rom_sum_bad(st[0]), .ram_bad(st[1]), .cpu_bad(st[2]),
    .last_track(4'h3), .op_req(op_req), .op_kind(kind), .op_lun(), .op_lba(lba), .op_ilv(),
    .op_step(op_step), .op_retry_dis(), .op_imm_ecc(), .op_fill_buf(fb), .op_fill_byte(fill),
    .op_hdr_only(), .op_verify(), .op_ack(op_ack), .op_code(op_code), .chk_ilv(8'h03),
    .chk_unformatted(unf), .chk_hdr_bad(hb));
  track_engine_model eng (.clk_sys(clk_sys), .rst_n(rst_n), .op_req(op_req), .lat(lat),
    .code_in(ec), .op_ack(op_ack), .op_code(op_code), .n_req(n_req));
  // Free running clock
  always #5 clk_sys = ~clk_sys;
  // Verdict and end of run
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Compare seen against expected
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Send one descriptor in order, then wait for completion
  task automatic run(input row_t r, input int k);
    logic [7:0] n0;
    int n;
    st <= r.st;
    ec <= r.ec;
    lat <= k[1:0];
    n0 = n_req;
    for (int i = 0; i < 6; i++) begin
      cmd_byte <= r.d[47-8*i -: 8];
      cmd_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (!cmd_ready && n < 40);
      if (!cmd_ready) fail_count++;
      if (!cmd_ready) finish_test();
    end
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 300);
    if (done !== 1'b1) fail_count++;
    if (done !== 1'b1) finish_test();
    check(done_code, r.ex);
    check(n_req - n0, r.nr);
    if (r.nr != 8'h00) check({fb, op_step}, {r.d[5], r.d[3:0]});
    $display("test %0d done", k);
  endtask
  // Table sweep, then reset and map clearing
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    st = 3'h0;
    ec = 6'h00;
    lat = 2'h0;
    hb = 1'b0;
    unf = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i]) run(rows[i], i);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    check({busy, cmd_ready, done, op_req}, 4'h8);
    check(fill, 8'h6C);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    run('{48'h0800_0020_0200, 6'h00, 3'h0, ERR_NONE, 8'h02}, 3);
    check(lba, 21'h0_0021);
    check(kind, OP_READ);
    // Header faults on a clean engine pass, retries off
    hb <= 1'b1;
    run('{48'h0500_0000_0380, 6'h00, 3'h0, ERR_FORMAT, 8'h01}, 20);
    hb <= 1'b0;
    unf <= 1'b1;
    run('{48'h0500_0000_0380, 6'h00, 3'h0, ERR_FORMAT, 8'h01}, 21);
    unf <= 1'b0;
    finish_test();
  end
endmodule
